/* mds_regs.svh */
// Register offsets, field positions, reset values and timing counts of the disc data separator
`ifndef MDS_REGS_SVH
`define MDS_REGS_SVH

// ==========================================================
// Register offsets (word index on the plain register port)
`define MDS_OFS_CTRL 3'h0
`define MDS_OFS_SYNC 3'h1
`define MDS_OFS_TXDATA 3'h2
`define MDS_OFS_RXDATA 3'h3
`define MDS_OFS_STATUS 3'h4

// ==========================================================
// Control register fields
`define MDS_CTRL_SRCSEL 0
`define MDS_CTRL_TWOBYTE 1
`define MDS_CTRL_ZSYNC 2
`define MDS_CTRL_RXHUNT 3

// Status register fields
`define MDS_ST_RDA 0
`define MDS_ST_CHECK 1
`define MDS_ST_SYNCED 2
`define MDS_ST_TXEMPTY 3
`define MDS_ST_APPEND 4
`define MDS_ST_OVERRUN 5

// ==========================================================
// Reset values
`define MDS_CTRL_RST 8'h00
`define MDS_SYNC_RST 8'h01

// ==========================================================
// Timing, each derived from the 25 ns clock period
`define MDS_CLK_NS 25
`define MDS_STRETCH_NS 500
`define MDS_NARROW_NS 50
`define MDS_REF_NS 1000
`define MDS_ZSYNC_NS 5000
`define MDS_STRETCH_CYC (`MDS_STRETCH_NS / `MDS_CLK_NS)
`define MDS_NARROW_CYC (`MDS_NARROW_NS / `MDS_CLK_NS)
`define MDS_REF_CYC (`MDS_REF_NS / `MDS_CLK_NS)
`define MDS_ZSYNC_CYC (`MDS_ZSYNC_NS / `MDS_CLK_NS)
`define MDS_CRC_POLY 16'h8005
`define MDS_CRC_BITS 16

`endif

/* mds_pkg.sv */
// Types shared by the disc data separator
package mds_pkg;

	// ==========================================================
	// Register port request, one cycle per access
	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} mds_bus_req_s;

	// ==========================================================
	// Receiver and transmitter states, one-hot
	typedef enum logic [1:0] {
		RX_HUNT = 2'b01,
		RX_DATA = 2'b10
	} mds_rx_e;

	typedef enum logic [2:0] {
		TX_PAYLOAD = 3'b001,
		TX_APPEND = 3'b010,
		TX_TAIL = 3'b100
	} mds_tx_e;

endpackage : mds_pkg

/* mds_data_separator.sv */
// MFM read data separator, serial adapter and CRC append/check path
`timescale 1ns/10ps
`include "mds_regs.svh"

module mds_data_separator
	import mds_pkg::*;
(
	input wire logic mclk,
	input wire logic resetn,
	input wire mds_bus_req_s busReq,
	output logic [7:0] busRdata,
	input wire logic rawDiscPulse,
	input wire logic sectorPulse,
	input wire logic writeControl,
	output logic stretchedPulse,
	output logic zero_sync_pulse,
	output logic receive_bit_clock,
	output logic receive_bit_clock_inverted,
	output logic transmit_bit_clock_true,
	output logic transmit_bit_clock_inverted,
	output logic writeSerialData,
	output logic receive_byte_pair_ready,
	output logic check_result
);

	// ==========================================================
	// Functions
	// One CRC division step, MSB first
	function automatic logic [15:0] crcStep(input logic [15:0] crc, input logic din);
		logic [15:0] nxt;
		nxt = {crc[14:0], 1'b0};
		if (crc[15] ^ din) begin
			nxt = nxt ^ `MDS_CRC_POLY;
		end
		return nxt;
	endfunction : crcStep

	// Rising edge of a level against its previous value
	function automatic logic riseOf(input logic now, input logic prev);
		return now & ~prev;
	endfunction : riseOf

	// ==========================================================
	// Registers and state
	logic [7:0] ctrlReg;
	logic [7:0] syncCode;
	logic [5:0] refCnt;
	logic refClk;
	logic inPrev;
	logic [4:0] stretchCnt;
	logic stRise;
	logic [1:0] narrowCnt;
	logic [7:0] zsCnt;
	logic [5:0] fbCnt;
	logic rxClk;
	logic sepBit;
	logic rxData;
	mds_rx_e rxState;
	logic [7:0] huntSr;
	logic [7:0] rxSr;
	logic [2:0] rxBitCnt;
	logic [7:0] queue [0:2];
	logic [2:0] qValid;
	logic overrun;
	mds_tx_e txState;
	logic [7:0] txHold;
	logic holdFull;
	logic [7:0] txShift;
	logic [2:0] txCnt;
	logic [3:0] apCnt;
	logic [15:0] crc;

	// ==========================================================
	// Source selector and pulse shaping
	wire srcRaw = ctrlReg[`MDS_CTRL_SRCSEL];
	wire inMux = srcRaw ? rawDiscPulse : refClk;
	wire startStretch = riseOf(inMux, inPrev) && (stretchCnt == 5'd0);
	wire narrowPulse = (narrowCnt != 2'd0);
	wire readMode = writeControl;
	assign stretchedPulse = (stretchCnt != 5'd0);

	// 1 MHz reference, half high half low
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			refCnt <= 6'd0;
			refClk <= 1'b0;
		end else begin
			refCnt <= (refCnt == 6'(`MDS_REF_CYC - 1)) ? 6'd0 : refCnt + 6'd1;
			refClk <= (refCnt < 6'(`MDS_REF_CYC / 2 - 1)) || (refCnt == 6'(`MDS_REF_CYC - 1));
		end
	end

	// Non-retriggerable one-shots; a second pulse inside the stretch is absorbed
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			inPrev <= 1'b0;
			stretchCnt <= 5'd0;
			stRise <= 1'b0;
			narrowCnt <= 2'd0;
		end else begin
			inPrev <= inMux;
			stRise <= startStretch;
			if (startStretch) begin
				stretchCnt <= 5'(`MDS_STRETCH_CYC);
			end else if (stretchCnt != 5'd0) begin
				stretchCnt <= stretchCnt - 5'd1;
			end
			if (stRise) begin
				narrowCnt <= 2'(`MDS_NARROW_CYC);
			end else if (narrowCnt != 2'd0) begin
				narrowCnt <= narrowCnt - 2'd1;
			end
		end
	end

	// ==========================================================
	// Zero sync one-shot, started by software
	wire zsStart = busReq.wr && (busReq.addr == `MDS_OFS_CTRL) && busReq.wdata[`MDS_CTRL_ZSYNC];
	assign zero_sync_pulse = (zsCnt != 8'd0);

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			zsCnt <= 8'd0;
		end else if (zsStart && zsCnt == 8'd0) begin
			zsCnt <= 8'(`MDS_ZSYNC_CYC);
		end else if (zsCnt != 8'd0) begin
			zsCnt <= zsCnt - 8'd1;
		end
	end

	// ==========================================================
	// Digital loop: counter from the master clock stands in for the oscillator
	// Corrections are small steps so a single noisy pulse cannot pull the phase far
	wire tick1M = (fbCnt == 6'(`MDS_REF_CYC - 1));
	wire phaseCorr = stRise && srcRaw;
	wire zsForce = zero_sync_pulse && stRise;
	wire rxRiseEv = tick1M && !rxClk && !zsForce;
	wire rxFallEv = tick1M && rxClk && !zsForce;
	logic [5:0] next_fbCnt;

	always_comb begin
		next_fbCnt = fbCnt + 6'd1;
		if (zsForce || tick1M) begin
			next_fbCnt = 6'd0;
		end else if (phaseCorr && fbCnt < 6'(`MDS_REF_CYC / 2)) begin
			next_fbCnt = fbCnt + 6'd2;
		end else if (phaseCorr) begin
			next_fbCnt = fbCnt;
		end
	end

	// Divide-by-two to the complementary bit clocks
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			fbCnt <= 6'd0;
			rxClk <= 1'b0;
		end else begin
			fbCnt <= next_fbCnt;
			if (zsForce) begin
				rxClk <= 1'b0;
			end else if (tick1M) begin
				rxClk <= ~rxClk;
			end
		end
	end

	assign receive_bit_clock = rxClk;
	assign receive_bit_clock_inverted = ~rxClk;
	assign transmit_bit_clock_true = ~rxClk;
	assign transmit_bit_clock_inverted = rxClk;

	// ==========================================================
	// Data window and the two separator flops
	wire windowHit = narrowPulse && rxClk;

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			sepBit <= 1'b0;
			rxData <= 1'b0;
		end else begin
			if (rxFallEv) begin
				sepBit <= 1'b0;
				rxData <= sepBit;
			end else if (windowHit) begin
				sepBit <= 1'b1;
			end
		end
	end

	// ==========================================================
	// Receiver: hunt for sync, then assemble bytes on the receive clock
	wire rxEn = readMode && (rxRiseEv);
	wire [7:0] huntNext = {huntSr[6:0], rxData};
	wire syncHit = (rxState == RX_HUNT) && rxEn && (huntNext == syncCode);
	wire [7:0] byteNext = {rxSr[6:0], rxData};
	wire bytePush = (rxState == RX_DATA) && rxEn && (rxBitCnt == 3'd7);
	wire huntCmd = busReq.wr && (busReq.addr == `MDS_OFS_CTRL) && busReq.wdata[`MDS_CTRL_RXHUNT];

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			rxState <= RX_HUNT;
			huntSr <= 8'h00;
			rxSr <= 8'h00;
			rxBitCnt <= 3'd0;
		end else if (huntCmd) begin
			rxState <= RX_HUNT;
			huntSr <= 8'h00;
		end else if (rxEn) begin
			case (rxState)
				RX_HUNT: begin
					huntSr <= huntNext;
					if (syncHit) begin
						rxState <= RX_DATA;
						rxBitCnt <= 3'd0;
					end
				end
				RX_DATA: begin
					rxSr <= byteNext;
					rxBitCnt <= rxBitCnt + 3'd1;
				end
				default: rxState <= RX_HUNT;
			endcase
		end
	end

	// ==========================================================
	// Three byte receive queue: enter at the top, fall to the last empty slot
	wire rxPop = busReq.rd && (busReq.addr == `MDS_OFS_RXDATA) && qValid[0];
	logic [2:0] next_qValid;
	logic [2:0] qMove;

	always_comb begin
		qMove = 3'b000;
		next_qValid = qValid;
		if (rxPop) begin
			next_qValid[0] = 1'b0;
		end
		qMove[0] = !next_qValid[0] && next_qValid[1];
		qMove[1] = !next_qValid[1] && next_qValid[2];
		if (qMove[0]) begin
			next_qValid[0] = 1'b1;
			next_qValid[1] = 1'b0;
		end
		if (qMove[1]) begin
			next_qValid[1] = 1'b1;
			next_qValid[2] = 1'b0;
		end
		qMove[2] = bytePush && !next_qValid[2];
		if (qMove[2]) begin
			next_qValid[2] = 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			qValid <= 3'b000;
			overrun <= 1'b0;
		end else begin
			qValid <= next_qValid;
			if (bytePush && !qMove[2]) begin
				overrun <= 1'b1; // Byte lost, queue full
			end else if (huntCmd) begin
				overrun <= 1'b0;
			end
		end
	end

	// Queue data, one move per slot per clock
	always_ff @(posedge mclk) begin
		for (int i = 0; i < 2; i++) begin
			if (qMove[i]) begin
				queue[i] <= queue[i+1];
			end
		end
		if (qMove[2]) begin
			queue[2] <= byteNext;
		end
	end

	wire twoByte = ctrlReg[`MDS_CTRL_TWOBYTE];
	wire rdaLevel = twoByte ? (qValid[0] && qValid[1]) : qValid[0];

	// ==========================================================
	// Transmitter and append selector, advancing on the transmit clock rise
	wire txEv = !readMode && rxFallEv;
	wire txLoad = (txState == TX_PAYLOAD) && (txCnt == 3'd0);
	wire underflow = txLoad && !holdFull;
	wire txWr = busReq.wr && (busReq.addr == `MDS_OFS_TXDATA);
	logic txBit;

	always_comb begin
		txBit = 1'b0;
		case (txState)
			TX_PAYLOAD: txBit = underflow ? crc[15] : (txLoad ? txHold[7] : txShift[7]);
			TX_APPEND: txBit = crc[15];
			TX_TAIL: txBit = 1'b0;
			default: txBit = 1'b0;
		endcase
	end

	// Selector output feeds the encoder
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			txState <= TX_PAYLOAD;
			txShift <= 8'h00;
			txCnt <= 3'd0;
			apCnt <= 4'd0;
			writeSerialData <= 1'b0;
		end else if (sectorPulse) begin
			txState <= TX_PAYLOAD;
			txCnt <= 3'd0;
		end else if (txEv) begin
			writeSerialData <= txBit;
			case (txState)
				TX_PAYLOAD: begin
					if (underflow) begin
						txState <= TX_APPEND;
						apCnt <= 4'(`MDS_CRC_BITS - 1);
					end else if (txLoad) begin
						txShift <= {txHold[6:0], 1'b0};
						txCnt <= 3'd7;
					end else begin
						txShift <= {txShift[6:0], 1'b0};
						txCnt <= txCnt - 3'd1;
					end
				end
				TX_APPEND: begin
					apCnt <= apCnt - 4'd1;
					if (apCnt == 4'd1) begin
						txState <= TX_TAIL;
					end
				end
				TX_TAIL: txState <= TX_TAIL;
				default: txState <= TX_PAYLOAD;
			endcase
		end
	end

	// Holding byte; a load by the shifter wins over nothing, a write always refills
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			holdFull <= 1'b0;
			txHold <= 8'h00;
		end else if (txWr) begin
			holdFull <= 1'b1;
			txHold <= busReq.wdata;
		end else if (txEv && txLoad && holdFull) begin
			holdFull <= 1'b0;
		end
	end

	// ==========================================================
	// CRC: generate on write, check on read; frozen feedback while appending
	wire crcTx = txEv && (txState == TX_PAYLOAD) && !underflow;
	wire crcShiftOut = txEv && (underflow || txState == TX_APPEND);
	wire crcRx = rxEn && (rxState == RX_DATA);
	logic [15:0] next_crc;

	always_comb begin
		next_crc = crc;
		if (sectorPulse) begin
			next_crc = 16'h0000;
		end else if (crcTx) begin
			next_crc = crcStep(crc, txBit);
		end else if (crcShiftOut) begin
			next_crc = {crc[14:0], 1'b0};
		end else if (crcRx) begin
			next_crc = crcStep(crc, rxData);
		end
	end

	// Check result follows every received bit, so after the stored check bytes it shows the verdict
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			crc <= 16'h0000;
			check_result <= 1'b0;
		end else begin
			crc <= next_crc;
			if (sectorPulse) begin
				check_result <= 1'b0;
			end else if (crcRx) begin
				check_result <= (next_crc != 16'h0000);
			end
		end
	end

	// ==========================================================
	// Register port: control, sync code, status and queue read
	wire [7:0] statusWord = {2'b00, overrun, (txState != TX_PAYLOAD), !holdFull,
		(rxState == RX_DATA), check_result, rdaLevel};

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			ctrlReg <= `MDS_CTRL_RST;
			syncCode <= `MDS_SYNC_RST;
			busRdata <= 8'h00;
			receive_byte_pair_ready <= 1'b0;
		end else begin
			receive_byte_pair_ready <= rdaLevel;
			if (busReq.wr && busReq.addr == `MDS_OFS_CTRL) begin
				ctrlReg <= {4'h0, 1'b0, 1'b0, busReq.wdata[1:0]};
			end
			if (busReq.wr && busReq.addr == `MDS_OFS_SYNC) begin
				syncCode <= busReq.wdata;
			end
			busRdata <= 8'h00;
			if (busReq.rd) begin
				case (busReq.addr)
					`MDS_OFS_CTRL: busRdata <= ctrlReg;
					`MDS_OFS_SYNC: busRdata <= syncCode;
					`MDS_OFS_RXDATA: busRdata <= qValid[0] ? queue[0] : 8'h00;
					`MDS_OFS_STATUS: busRdata <= statusWord;
					default: busRdata <= 8'h00;
				endcase
			end
		end
	end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);

	sequence s_stretchHold;
		##19 stretchedPulse ##1 !stretchedPulse;
	endsequence

	sequence s_zsHold;
		##199 zero_sync_pulse ##1 !zero_sync_pulse;
	endsequence

	property p_stretch;
		$rose(stretchedPulse) |-> s_stretchHold;
	endproperty
	a_stretch: assert property (p_stretch) else $error("stretched pulse not 500 ns");

	property p_narrow;
		$rose(narrowPulse) |-> ##1 narrowPulse ##1 !narrowPulse;
	endproperty
	a_narrow: assert property (p_narrow) else $error("narrow pulse not 50 ns");

	property p_zero_sync;
		$rose(zero_sync_pulse) |-> s_zsHold;
	endproperty
	a_zero_sync: assert property (p_zero_sync) else $error("zero sync pulse not 5 us");

	property p_source;
		srcRaw |-> (inMux == rawDiscPulse);
	endproperty
	a_source: assert property (p_source) else $error("source selector wrong");

	property p_window;
		$rose(sepBit) |-> $past(rxClk) && $past(narrowPulse);
	endproperty
	a_window: assert property (p_window) else $error("bit set outside data window");

	property p_sep_reset;
		rxFallEv |=> !sepBit;
	endproperty
	a_sep_reset: assert property (p_sep_reset) else $error("separator flop not cleared at cell start");

	property p_retime;
		rxFallEv |=> (rxData == $past(sepBit));
	endproperty
	a_retime: assert property (p_retime) else $error("receive data not retimed");

	property p_detector;
		($past(fbCnt) < 6'd38) && (fbCnt == $past(fbCnt) + 6'd2) |-> $past(stRise);
	endproperty
	a_detector: assert property (p_detector) else $error("correction without data pulse");

	property p_append;
		txEv && underflow && !sectorPulse |=> (txState == TX_APPEND) && (writeSerialData == $past(crc[15]));
	endproperty
	a_append: assert property (p_append) else $error("append switch did not flip");

	property p_advance;
		!qValid[0] && qValid[1] |=> qValid[0];
	endproperty
	a_advance: assert property (p_advance) else $error("queue byte did not advance");

	property p_crc_clear;
		sectorPulse |=> (crc == 16'h0000) && !check_result;
	endproperty
	a_crc_clear: assert property (p_crc_clear) else $error("crc not cleared by sector");

	property p_rda;
		twoByte && qValid[0] && qValid[1] |=> receive_byte_pair_ready;
	endproperty
	a_rda: assert property (p_rda) else $error("byte pair ready missing");

endmodule : mds_data_separator

/* mds_drive_model.sv */
// Flexible disc drive model: MFM read pulses placed against the receive bit clock
`timescale 1ns/10ps

module mds_drive_model (
	input wire logic mclk,
	input wire logic receive_bit_clock,
	output logic rawDiscPulse
);
	// ==========
	// One flux pulse; width varies like a real read buffer, well under the stretch time
	task automatic flux();
		int w;
		w = 8 + $urandom % 5;
		rawDiscPulse <= 1'b1;
		repeat (w) @(posedge mclk);
		rawDiscPulse <= 1'b0;
	endtask : flux

	// Clock pulse in the first half only between two zeros, data pulse in the second half
	task automatic play(input logic b[$]);
		logic prev;
		prev = 1'b1;
		foreach (b[i]) begin
			@(negedge receive_bit_clock);
			repeat (10) @(posedge mclk);
			if (!prev && !b[i]) flux();
			@(posedge receive_bit_clock);
			repeat (10) @(posedge mclk);
			if (b[i]) flux();
			prev = b[i];
		end
	endtask : play

	// Line idles low between pulses
	initial rawDiscPulse = 1'b0;
endmodule : mds_drive_model

/* testbench.sv */
// Self-checking bench for the disc data separator
`timescale 1ns/10ps
`include "mds_regs.svh"

module testbench;
	import mds_pkg::*;
	logic mclk, resetn, tbPulse, drvPulse, sectorPulse, writeControl, clkCheck, ckLast;
	wire logic rawDiscPulse;
	mds_bus_req_s busReq;
	logic [7:0] busRdata;
	logic stretchedPulse, zero_sync_pulse, receive_bit_clock, receive_bit_clock_inverted;
	logic transmit_bit_clock_true, transmit_bit_clock_inverted, writeSerialData;
	logic receive_byte_pair_ready, check_result;
	int miscompares, compares, spRun, zsRun, ckRun, spRises;

	// ==========
	// Design and drive
	assign rawDiscPulse = tbPulse | drvPulse;
	mds_data_separator i_mds_data_separator (
		.mclk(mclk), .resetn(resetn), .busReq(busReq), .busRdata(busRdata),
		.rawDiscPulse(rawDiscPulse), .sectorPulse(sectorPulse), .writeControl(writeControl),
		.stretchedPulse(stretchedPulse), .zero_sync_pulse(zero_sync_pulse),
		.receive_bit_clock(receive_bit_clock), .receive_bit_clock_inverted(receive_bit_clock_inverted),
		.transmit_bit_clock_true(transmit_bit_clock_true),
		.transmit_bit_clock_inverted(transmit_bit_clock_inverted), .writeSerialData(writeSerialData),
		.receive_byte_pair_ready(receive_byte_pair_ready), .check_result(check_result)
	);
	mds_drive_model i_mds_drive_model (
		.mclk(mclk), .receive_bit_clock(receive_bit_clock), .rawDiscPulse(drvPulse)
	);

	// 40 MHz clock
	initial mclk = 1'b0;
	always #12.5 mclk = ~mclk;

	// ==========
	// Compare tasks
	task automatic tally(input logic ok, input logic [31:0] a, input logic [31:0] e);
		compares++;
		if (ok !== 1'b1) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, a, e);
		end
	endtask : tally
	task automatic chk_bit(input logic a, input logic e);
		tally(a === e, 32'(a), 32'(e));
	endtask : chk_bit
	task automatic chk_byte(input logic [7:0] a, input logic [7:0] e);
		tally(a === e, 32'(a), 32'(e));
	endtask : chk_byte
	task automatic chk_count(input int a, input int e);
		tally(a == e, a, e);
	endtask : chk_count

	task automatic test_done();
		if (miscompares == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : test_done

	// ==========
	// Register port: one-cycle strobes, read data sampled in the following cycle
	task automatic bus_write(input logic [2:0] a, input logic [7:0] d);
		@(posedge mclk);
		busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge mclk);
		busReq.wr <= 1'b0;
	endtask : bus_write
	task automatic bus_read(input logic [2:0] a, output logic [7:0] d);
		@(posedge mclk);
		busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge mclk);
		busReq.rd <= 1'b0;
		#1 d = busRdata;
	endtask : bus_read

	task automatic pulse(input int w);
		@(posedge mclk);
		tbPulse <= 1'b1;
		repeat (w) @(posedge mclk);
		tbPulse <= 1'b0;
	endtask : pulse

	task automatic sector_mark();
		@(posedge mclk);
		sectorPulse <= 1'b1;
		@(posedge mclk);
		sectorPulse <= 1'b0;
	endtask : sector_mark

	// Check bits, MSB first, zero start value
	function automatic logic [15:0] crc16(input logic [7:0] q[$]);
		logic [15:0] c;
		c = 16'h0000;
		foreach (q[i]) for (int k = 7; k >= 0; k--) c = {c[14:0], 1'b0} ^ ((c[15] ^ q[i][k]) ? `MDS_CRC_POLY : 16'h0000);
		return c;
	endfunction : crc16

	// ==========
	// Pulse widths and bit clock half periods, judged when each run ends
	always @(posedge mclk) begin
		if (resetn) begin
			spRun <= stretchedPulse ? spRun + 1 : 0;
			zsRun <= zero_sync_pulse ? zsRun + 1 : 0;
			if (stretchedPulse && spRun == 0) spRises <= spRises + 1;
			if (!stretchedPulse && spRun != 0) chk_count(spRun, 20);
			if (!zero_sync_pulse && zsRun != 0) chk_count(zsRun, 200);
			ckRun <= (receive_bit_clock !== ckLast) ? 1 : ckRun + 1;
			if (clkCheck && receive_bit_clock !== ckLast) chk_count(ckRun, 40);
			ckLast <= receive_bit_clock;
			chk_bit(transmit_bit_clock_true, ~receive_bit_clock);
			chk_bit(transmit_bit_clock_inverted, receive_bit_clock);
			chk_bit(receive_bit_clock_inverted, ~receive_bit_clock);
		end
	end

	// ==========
	// Write: payload, then check bits with no gap, then zeros
	task automatic write_sector();
		logic [7:0] pay[$];
		logic exp[$];
		logic [15:0] c;
		pay = {8'($urandom), 8'($urandom)};
		c = crc16(pay);
		exp = {};
		foreach (pay[i]) for (int k = 7; k >= 0; k--) exp.push_back(pay[i][k]);
		for (int k = 15; k >= 0; k--) exp.push_back(c[k]);
		repeat (4) exp.push_back(1'b0);
		writeControl <= 1'b0;
		bus_write(`MDS_OFS_CTRL, 8'h00);
		repeat (2) @(negedge receive_bit_clock);
		clkCheck = 1'b1;
		sector_mark();
		bus_write(`MDS_OFS_TXDATA, pay[0]);
		foreach (exp[i]) begin
			@(negedge receive_bit_clock);
			repeat (2) @(posedge mclk);
			#1 chk_bit(writeSerialData, exp[i]);
			if (i == 0) bus_write(`MDS_OFS_TXDATA, pay[1]);
		end
		clkCheck = 1'b0;
	endtask : write_sector

	// Read: preamble, sync, four bytes and check bits; bad flips one check bit
	task automatic read_sector(input logic bad);
		logic [7:0] pay[$];
		logic bits[$];
		logic [15:0] c;
		logic [7:0] d;
		pay = {};
		repeat (4) pay.push_back(8'($urandom));
		c = crc16(pay) ^ {15'h0000, bad};
		pay.push_back(c[15:8]);
		pay.push_back(c[7:0]);
		bits = {};
		repeat (16) bits.push_back(1'b0);
		bits.push_back(1'b1);
		foreach (pay[i]) for (int k = 7; k >= 0; k--) bits.push_back(pay[i][k]);
		repeat (6) bits.push_back(1'b0);
		// Raw source and a fresh hunt first; two idle cells drain bits that the reference left in the separator
		@(posedge mclk);
		writeControl <= 1'b1;
		bus_write(`MDS_OFS_CTRL, 8'h0b);
		repeat (200) @(posedge mclk);
		sector_mark();
		bus_write(`MDS_OFS_SYNC, 8'h01);
		bus_write(`MDS_OFS_CTRL, 8'h0f);
		repeat (3) @(posedge mclk);
		chk_bit(zero_sync_pulse, 1'b1);
		fork
			i_mds_drive_model.play(bits);
			for (int p = 0; p < 3; p++) begin
				for (int t = 0; t < 4000 && receive_byte_pair_ready !== 1'b1; t++) @(posedge mclk);
				chk_bit(receive_byte_pair_ready, 1'b1);
				bus_read(`MDS_OFS_RXDATA, d);
				chk_byte(d, pay[2 * p]);
				bus_read(`MDS_OFS_RXDATA, d);
				chk_byte(d, pay[2 * p + 1]);
				repeat (2) @(posedge mclk);
				chk_bit(receive_byte_pair_ready, 1'b0);
			end
		join
		repeat (4) @(posedge mclk);
		chk_bit(check_result, bad);
		bus_read(`MDS_OFS_STATUS, d);
		chk_bit(d[`MDS_ST_CHECK], bad);
	endtask : read_sector

	// ==========
	// Main sequence
	initial begin
		logic [7:0] d, e;
		int n;
		void'($urandom(11));
		resetn = 1'b0;
		busReq = '0;
		tbPulse = 1'b0;
		sectorPulse = 1'b0;
		// Receiver held off until the first read, so the reference cannot fill the queue early
		writeControl = 1'b0;
		clkCheck = 1'b0;
		repeat (8) @(posedge mclk);
		resetn <= 1'b1;
		// Reset values, unmapped reads and random read-back
		bus_read(`MDS_OFS_CTRL, d);
		chk_byte(d, `MDS_CTRL_RST);
		bus_read(`MDS_OFS_SYNC, d);
		chk_byte(d, `MDS_SYNC_RST);
		chk_bit(check_result, 1'b0);
		for (int a = 5; a < 8; a++) begin
			bus_read(3'(a), d);
			chk_byte(d, 8'h00);
		end
		repeat (4) begin
			e = 8'($urandom);
			bus_write(`MDS_OFS_SYNC, e);
			bus_read(`MDS_OFS_SYNC, d);
			chk_byte(d, e);
		end
		// Pulse shaping: an edge inside a stretch is ignored
		bus_write(`MDS_OFS_CTRL, 8'h01);
		repeat (30) @(posedge mclk);
		n = spRises;
		pulse(1 + $urandom % 4);
		repeat (5) @(posedge mclk);
		pulse(3);
		repeat (30) @(posedge mclk);
		chk_count(spRises - n, 1);
		pulse(2);
		repeat (30) @(posedge mclk);
		chk_count(spRises - n, 2);
		// Reference selected: raw pulses must not get through
		bus_write(`MDS_OFS_CTRL, 8'h00);
		n = spRises;
		// Raw pulses spaced wider than a stretch: a leak would give 16 stretches, the reference about 10
		repeat (16) begin
			pulse(1 + $urandom % 3);
			repeat (22) @(posedge mclk);
		end
		chk_bit((spRises - n) inside {[9:12]}, 1'b1);
		write_sector();
		read_sector(1'b0);
		read_sector(1'b1);
		test_done();
	end

	// Watchdog, about four times the expected run
	initial begin
		repeat (60000) @(posedge mclk);
		miscompares++;
		test_done();
	end
endmodule : testbench
